/* hw/spfc_pkg.sv */
// constants, field layout and carriers for the self-program flash control block
// assumes one 25 MHz clock shared by the core, the bus and this block
package spfc_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam int CTRL_W = 5;
    localparam int BIT_EN = 0;
    localparam logic [4:0] CMD_LOAD = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_FUSE = 5'h09;
    localparam logic [4:0] CMD_CLEAR = 5'h11;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam logic [2:0] ARM_CYCLES = 3'h4;
    localparam logic [2:0] FUSE_CYCLES = 3'h3;
    localparam int WORDS = 16;
    localparam logic [15:0] BUF_ERASED = 16'hffff;
    localparam logic [1:0] Z_FUSE_LOW = 2'h0;
    localparam logic [1:0] Z_LOCK = 2'h1;
    localparam logic [1:0] Z_FUSE_HIGH = 2'h3;
    localparam int CLK_NS = 40;
    localparam int PROG_TIME_NS = 3_700_000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    // request from the core, valid for one cycle
    typedef struct packed {
        logic store_program_op;
        logic load_program_op;
        logic [15:0] z_ptr;
        logic [15:0] r1r0;
    } spfc_core_req_type;
    // command to the flash array, pulses one cycle
    typedef struct packed {
        logic erase_go;
        logic write_go;
        logic [4:0] page;
    } spfc_flash_cmd_type;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_BUSY = 3'b100
    } spfc_state_type;
endpackage

/* hw/spfc_top.sv */
// self-program flash sequencer: control register on AHB-Lite, core requests in
// assumes core, eeprom status and fuse straps all on hclk
//
// Register access over AHB-Lite and the address map were left to the implementer.
module spfc_top #(
    parameter int PROG_CYCLES = spfc_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // core side
    input wire spfc_pkg::spfc_core_req_type core_req,
    output logic cpu_halt,
    output logic lpm_hit,
    output logic [7:0] lpm_data,
    // neighbours
    input wire logic ee_busy,
    input wire logic [7:0] fuse_low,
    input wire logic [7:0] fuse_high,
    input wire logic [7:0] lock_bits,
    // flash array
    output spfc_pkg::spfc_flash_cmd_type flash_cmd,
    input wire logic [3:0] buf_rd_idx,
    output logic [15:0] buf_rd_data
);
    spfc_pkg::spfc_state_type state;
    logic [4:0] ctrl;
    logic [2:0] cnt;
    logic [31:0] timer;
    logic wr_q;
    logic sel_q;
    logic [15:0] buf_data [spfc_pkg::WORDS];
    logic [spfc_pkg::WORDS-1:0] loaded;

    // bus decode
    wire addr_ok = haddr[7:0] == spfc_pkg::ADDR_CTRL && haddr[31:8] == 24'h00_0000;
    wire take = hsel && hready && htrans == spfc_pkg::HTRANS_NONSEQ;
    wire wr_fire = wr_q && sel_q;
    wire [4:0] wdat = hwdata[4:0];
    wire pat_ok = wdat == spfc_pkg::CMD_LOAD || wdat == spfc_pkg::CMD_ERASE
        || wdat == spfc_pkg::CMD_WRITE || wdat == spfc_pkg::CMD_FUSE
        || wdat == spfc_pkg::CMD_CLEAR;
    wire idle = state == spfc_pkg::ST_IDLE;
    wire armed = state == spfc_pkg::ST_ARMED;
    wire busy = state == spfc_pkg::ST_BUSY;
    wire accept_wr = wr_fire && pat_ok && idle && !ee_busy;
    wire clr_cmd = accept_wr && wdat == spfc_pkg::CMD_CLEAR;

    // command decode of the armed register
    wire is_load = ctrl == spfc_pkg::CMD_LOAD;
    wire is_erase = ctrl == spfc_pkg::CMD_ERASE;
    wire is_write = ctrl == spfc_pkg::CMD_WRITE;
    wire is_fuse = ctrl == spfc_pkg::CMD_FUSE;
    wire spm_go = core_req.store_program_op && armed && !ee_busy;
    wire fuse_win = armed && is_fuse && cnt > spfc_pkg::ARM_CYCLES - spfc_pkg::FUSE_CYCLES;
    wire lpm_go = core_req.load_program_op && fuse_win && !ee_busy;
    wire [2:0] last_cnt = is_fuse ? spfc_pkg::ARM_CYCLES - spfc_pkg::FUSE_CYCLES + 3'h1 : 3'h1;
    wire timeout = armed && !spm_go && !lpm_go && cnt == last_cnt;
    wire op_start = spm_go && (is_erase || is_write);
    wire op_done = busy && timer == 32'h0000_0000;
    wire load_hit = spm_go && is_load;
    wire [3:0] load_idx = core_req.z_ptr[4:1];
    wire clr_buf = clr_cmd || (op_done && is_write);

    // fuse or lock selection by low Z bits
    wire [1:0] zsel = core_req.z_ptr[1:0];
    wire [7:0] fuse_sel = zsel == spfc_pkg::Z_LOCK ? lock_bits :
        zsel == spfc_pkg::Z_FUSE_HIGH ? fuse_high :
        zsel == spfc_pkg::Z_FUSE_LOW ? fuse_low : 8'hff;

    // bus address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q <= 1'b0;
            sel_q <= 1'b0;
        end
        else
        begin
            wr_q <= take && hwrite;
            sel_q <= take && addr_ok;
        end
    end

    // read data, zero wait, always okay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= (take && !hwrite && addr_ok) ? {27'h000_0000, ctrl} : 32'h0000_0000;
        end
    end

    // sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= spfc_pkg::ST_IDLE;
            ctrl <= spfc_pkg::CTRL_RESET;
            cnt <= 3'h0;
            timer <= 32'h0000_0000;
        end
        else
        begin
            unique case (state)
                spfc_pkg::ST_IDLE:
                begin
                    if (accept_wr)
                    begin
                        ctrl <= wdat;
                        cnt <= spfc_pkg::ARM_CYCLES;
                        state <= spfc_pkg::ST_ARMED;
                    end
                end
                spfc_pkg::ST_ARMED:
                begin
                    if (op_start)
                    begin
                        timer <= 32'(PROG_CYCLES - 1);
                        state <= spfc_pkg::ST_BUSY;
                    end
                    else if (spm_go || lpm_go || timeout)
                    begin
                        ctrl <= spfc_pkg::CTRL_RESET;
                        state <= spfc_pkg::ST_IDLE;
                    end
                    else
                    begin
                        cnt <= cnt - 3'h1;
                    end
                end
                spfc_pkg::ST_BUSY:
                begin
                    if (op_done)
                    begin
                        ctrl <= spfc_pkg::CTRL_RESET;
                        state <= spfc_pkg::ST_IDLE;
                    end
                    else
                    begin
                        timer <= timer - 32'h0000_0001;
                    end
                end
            endcase
        end
    end

    // core and flash outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cpu_halt <= 1'b0;
            lpm_hit <= 1'b0;
            lpm_data <= 8'h00;
            flash_cmd <= '0;
        end
        else
        begin
            cpu_halt <= op_start || (busy && !op_done);
            lpm_hit <= lpm_go;
            lpm_data <= lpm_go ? fuse_sel : lpm_data;
            flash_cmd.erase_go <= op_start && is_erase;
            flash_cmd.write_go <= op_start && is_write;
            flash_cmd.page <= op_start ? core_req.z_ptr[8:4] : flash_cmd.page;
        end
    end

    // temporary page buffer, one word per entry
    for (genvar i = 0; i < spfc_pkg::WORDS; i++)
    begin : g_buf
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                buf_data[i] <= spfc_pkg::BUF_ERASED;
                loaded[i] <= 1'b0;
            end
            else if (clr_buf)
            begin
                buf_data[i] <= spfc_pkg::BUF_ERASED;
                loaded[i] <= 1'b0;
            end
            else if (load_hit && load_idx == 4'(i) && !loaded[i])
            begin
                buf_data[i] <= core_req.r1r0;
                loaded[i] <= 1'b1;
            end
        end
    end

    // buffer readout for the flash array
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            buf_rd_data <= spfc_pkg::BUF_ERASED;
        else
            buf_rd_data <= buf_data[buf_rd_idx];
    end

    // checks
    property p_resv;
        @(posedge hclk) disable iff (!hresetn) hrdata[31:5] == 27'h000_0000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    property p_clr;
        @(posedge hclk) disable iff (!hresetn) clr_cmd |=> loaded == '0;
    endproperty
    a_clr: assert property (p_clr) else $error("buffer not cleared");
    property p_fuse;
        @(posedge hclk) disable iff (!hresetn) lpm_go |=> lpm_hit && lpm_data == $past(fuse_sel);
    endproperty
    a_fuse: assert property (p_fuse) else $error("fuse read missing");
    property p_write;
        @(posedge hclk) disable iff (!hresetn)
            spm_go && is_write |=> flash_cmd.write_go && flash_cmd.page == $past(core_req.z_ptr[8:4]);
    endproperty
    a_write: assert property (p_write) else $error("page write not issued");
    property p_halt;
        @(posedge hclk) disable iff (!hresetn) op_start |=> cpu_halt [*8];
    endproperty
    a_halt: assert property (p_halt) else $error("core not halted");
    property p_erase;
        @(posedge hclk) disable iff (!hresetn) spm_go && is_erase |=> flash_cmd.erase_go && busy;
    endproperty
    a_erase: assert property (p_erase) else $error("page erase not issued");
    property p_arm;
        @(posedge hclk) disable iff (!hresetn)
            accept_wr && wdat != spfc_pkg::CMD_FUSE ##1 (!spm_go) [*3]
            |-> armed && $past(armed) && $past(armed, 2) ##1 armed ##1 !armed;
    endproperty
    a_arm: assert property (p_arm) else $error("arming window wrong");
    property p_tmo;
        @(posedge hclk) disable iff (!hresetn) timeout |=> ctrl == spfc_pkg::CTRL_RESET && idle;
    endproperty
    a_tmo: assert property (p_tmo) else $error("enable not cleared");
    property p_busy_en;
        @(posedge hclk) disable iff (!hresetn) busy |-> ctrl[spfc_pkg::BIT_EN] && cpu_halt;
    endproperty
    a_busy_en: assert property (p_busy_en) else $error("enable dropped while busy");
    property p_bad;
        @(posedge hclk) disable iff (!hresetn) wr_fire && !pat_ok && idle |=> idle && $stable(ctrl);
    endproperty
    a_bad: assert property (p_bad) else $error("bad pattern acted");
    property p_ee;
        @(posedge hclk) disable iff (!hresetn) ee_busy && idle |=> idle;
    endproperty
    a_ee: assert property (p_ee) else $error("armed during eeprom write");
    property p_wr_done;
        @(posedge hclk) disable iff (!hresetn)
            op_done && is_write |=> ctrl == spfc_pkg::CTRL_RESET && idle && loaded == '0;
    endproperty
    a_wr_done: assert property (p_wr_done) else $error("page write did not finish cleanly");
    property p_er_done;
        @(posedge hclk) disable iff (!hresetn)
            op_done && is_erase |=> ctrl == spfc_pkg::CTRL_RESET && idle && !cpu_halt;
    endproperty
    a_er_done: assert property (p_er_done) else $error("page erase did not finish cleanly");
    property p_halt_end;
        @(posedge hclk) disable iff (!hresetn) $fell(cpu_halt) |-> idle && $past(op_done);
    endproperty
    a_halt_end: assert property (p_halt_end) else $error("core released before flash done");
    property p_load;
        @(posedge hclk) disable iff (!hresetn)
            load_hit && !loaded[load_idx] |=> buf_data[$past(load_idx)] == $past(core_req.r1r0);
    endproperty
    a_load: assert property (p_load) else $error("buffer word not loaded");
    property p_once;
        @(posedge hclk) disable iff (!hresetn)
            load_hit && loaded[load_idx] |=> buf_data[$past(load_idx)] == $past(buf_data[load_idx]);
    endproperty
    a_once: assert property (p_once) else $error("buffer word loaded twice");
    property p_unarmed;
        @(posedge hclk) disable iff (!hresetn)
            core_req.store_program_op && idle && !accept_wr
            |=> idle && $stable(loaded) && !flash_cmd.erase_go && !flash_cmd.write_go;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("unarmed store acted");
    property p_ee_block;
        @(posedge hclk) disable iff (!hresetn)
            ee_busy && !busy |=> !flash_cmd.erase_go && !flash_cmd.write_go && !lpm_hit;
    endproperty
    a_ee_block: assert property (p_ee_block) else $error("flash op during eeprom write");
    property p_lock;
        @(posedge hclk) disable iff (!hresetn)
            lpm_go && zsel == spfc_pkg::Z_LOCK |=> lpm_data == $past(lock_bits);
    endproperty
    a_lock: assert property (p_lock) else $error("lock byte not returned");
    property p_rst;
        @(posedge hclk) $rose(hresetn) |-> ctrl == spfc_pkg::CTRL_RESET && loaded == '0 && !cpu_halt;
    endproperty
    a_rst: assert property (p_rst) else $error("state not cleared by reset");
endmodule

/* dv/spfc_core_model.sv */
// partner model: the core issuing store and load program ops
// assumes the bench names each op; a halted core issues nothing
module spfc_core_model (
    // clock and halt
    input wire logic hclk,
    input wire logic cpu_halt,
    // request to the sequencer
    output spfc_pkg::spfc_core_req_type core_req
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle until the first op
    initial core_req = '0;

    // one-cycle op pulse, then operands scrambled once released
    task automatic issue(input logic st, input logic [15:0] z, input logic [15:0] d);
        int n;
        for (n = 0; n < 100 && cpu_halt !== 1'b0; n++) @(posedge hclk);
        testbench.bound(n);
        core_req <= '{store_program_op: st, load_program_op: !st, z_ptr: z, r1r0: d};
        @(posedge hclk);
        core_req <= '{store_program_op: 1'b0, load_program_op: 1'b0, z_ptr: ~z, r1r0: ~d};
        @(posedge hclk);
    endtask
endmodule

/* dv/testbench.sv */
// self-checking bench for the self-program flash sequencer
// assumes one ahb-lite master and the core model on the same clock
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG = 20;
    typedef struct packed { logic [7:0] wr; logic [7:0] rd; } spfc_row_type;
    spfc_row_type rows [8] = '{16'h0101, 16'h0303, 16'h0505, 16'h0909, 16'h1111, 16'he101, 16'h0200, 16'h0700};
    logic [1:0] fz [3] = '{2'h0, 2'h1, 2'h3};
    logic [7:0] fe [3] = '{8'h5a, 8'h3c, 8'hc3};
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ee_busy = 0;
    logic hreadyout, hresp, cpu_halt, lpm_hit;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
    logic [1:0] htrans = '0;
    logic [7:0] lpm_data;
    logic [3:0] buf_rd_idx = '0;
    logic [15:0] buf_rd_data;
    logic [4:0] last_page = '0;
    spfc_pkg::spfc_core_req_type core_req;
    spfc_pkg::spfc_flash_cmd_type flash_cmd;
    int miscompares = 0, num_checks = 0, n_erase = 0, n_write = 0, n_halt = 0;

    // 25 MHz clock
    always #20 hclk = ~hclk;

    spfc_top #(.PROG_CYCLES(PROG)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .core_req(core_req), .cpu_halt(cpu_halt),
        .lpm_hit(lpm_hit), .lpm_data(lpm_data), .ee_busy(ee_busy), .fuse_low(8'h5a), .fuse_high(8'hc3),
        .lock_bits(8'h3c), .flash_cmd(flash_cmd), .buf_rd_idx(buf_rd_idx), .buf_rd_data(buf_rd_data));
    spfc_core_model u_core (.hclk(hclk), .cpu_halt(cpu_halt), .core_req(core_req));

    // flash pulses, page and halt length seen at the ports
    always @(posedge hclk)
    begin
        if (flash_cmd.erase_go === 1'b1) n_erase <= n_erase + 1;
        if (flash_cmd.write_go === 1'b1) n_write <= n_write + 1;
        if (flash_cmd.erase_go === 1'b1 || flash_cmd.write_go === 1'b1) last_page <= flash_cmd.page;
        if (cpu_halt === 1'b1) n_halt <= n_halt + 1;
    end

    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // a wait that runs out counts as a mismatch and ends the run
    task automatic bound(input int n);
        if (n >= 100)
        begin
            miscompares++;
            complete_run();
        end
    endtask

    task automatic wait_ready();
        int n;
        @(posedge hclk);
        for (n = 0; n < 100 && hreadyout !== 1'b1; n++) @(posedge hclk);
        bound(n);
    endtask

    // one single-word transfer, read data kept in rd
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= spfc_pkg::HTRANS_NONSEQ;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask

    task automatic wait_halt();
        int n;
        for (n = 0; n < 100 && cpu_halt !== 1'b0; n++) @(posedge hclk);
        bound(n);
        @(posedge hclk);
    endtask

    task automatic chk_buf(input logic [3:0] i, input logic [15:0] e);
        buf_rd_idx <= i;
        repeat (3) @(posedge hclk);
        chk("buffer word", {16'h0, e}, {16'h0, buf_rd_data});
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("ready and okay", 32'h1, {30'h0, hresp, hreadyout});
        bus(1'b0, 32'h0, 32'h0);
        chk("control at reset", 32'h0, rd);
        // unmapped read while armed, then an unmapped write
        bus(1'b1, 32'h0, 32'h1);
        bus(1'b0, 32'h4, 32'h0);
        chk("unmapped read", 32'h0, rd);
        repeat (6) @(posedge hclk);
        bus(1'b1, 32'h4, 32'h3);
        bus(1'b0, 32'h0, 32'h0);
        chk("unmapped write", 32'h0, rd);
        foreach (rows[i])
        begin
            bus(1'b1, 32'h0, {24'h0, rows[i].wr});
            bus(1'b0, 32'h0, 32'h0);
            chk("control after write", {24'h0, rows[i].rd}, rd);
            repeat (6) @(posedge hclk);
            bus(1'b0, 32'h0, 32'h0);
            chk("control after timeout", 32'h0, rd);
        end
        // buffer load, then a second load of the same word
        bus(1'b1, 32'h0, 32'h1);
        u_core.issue(1'b1, 16'h0007, 16'h1234);
        chk_buf(4'h3, 16'h1234);
        bus(1'b1, 32'h0, 32'h1);
        u_core.issue(1'b1, 16'h0006, 16'h5678);
        chk_buf(4'h3, 16'h1234);
        bus(1'b1, 32'h0, 32'h11);
        chk_buf(4'h3, 16'hffff);
        repeat (6) @(posedge hclk);
        // page erase
        bus(1'b1, 32'h0, 32'h3);
        u_core.issue(1'b1, 16'h01a0, 16'h0);
        bus(1'b0, 32'h0, 32'h0);
        chk("control while busy", 32'h3, rd);
        wait_halt();
        chk("erase count", 32'h1, 32'(n_erase));
        chk("erase page", 32'h1a, {27'h0, last_page});
        chk("halt cycles", 32'(PROG), 32'(n_halt));
        bus(1'b0, 32'h0, 32'h0);
        chk("control after erase", 32'h0, rd);
        // page write after one load
        bus(1'b1, 32'h0, 32'h1);
        u_core.issue(1'b1, 16'h000a, 16'hbeef);
        chk_buf(4'h5, 16'hbeef);
        bus(1'b1, 32'h0, 32'h5);
        u_core.issue(1'b1, 16'h0050, 16'h0);
        wait_halt();
        chk("write count", 32'h1, 32'(n_write));
        chk("write page", 32'h5, {27'h0, last_page});
        chk("halt cycles", 32'(2 * PROG), 32'(n_halt));
        chk_buf(4'h5, 16'hffff);
        bus(1'b0, 32'h0, 32'h0);
        chk("control after write", 32'h0, rd);
        // fuse and lock reads, z set with the load op right after arming
        foreach (fz[i])
        begin
            bus(1'b1, 32'h0, 32'h9);
            u_core.issue(1'b0, {14'h0, fz[i]}, 16'h0);
            chk("fuse or lock byte", {24'h0, fe[i]}, {24'h0, lpm_data});
            chk("fuse read strobe", 32'h1, {31'h0, lpm_hit});
        end
        // store on the last armed cycle lands, one cycle later is refused
        bus(1'b1, 32'h0, 32'h1);
        repeat (3) @(posedge hclk);
        u_core.issue(1'b1, 16'h000c, 16'h0c0c);
        chk_buf(4'h6, 16'h0c0c);
        bus(1'b1, 32'h0, 32'h1);
        repeat (4) @(posedge hclk);
        u_core.issue(1'b1, 16'h000e, 16'h0e0e);
        chk_buf(4'h7, 16'hffff);
        // eeprom write blocks arming; unarmed store does nothing
        ee_busy <= 1'b1;
        bus(1'b1, 32'h0, 32'h3);
        bus(1'b0, 32'h0, 32'h0);
        chk("control during eeprom write", 32'h0, rd);
        u_core.issue(1'b1, 16'h0010, 16'h0);
        chk_buf(4'h8, 16'hffff);
        chk("erase count", 32'h1, 32'(n_erase));
        ee_busy <= 1'b0;
        u_core.issue(1'b1, 16'h0012, 16'h1111);
        chk_buf(4'h9, 16'hffff);
        // reset in mid-run drops loaded words; control bits are already clear after the load
        bus(1'b1, 32'h0, 32'h1);
        u_core.issue(1'b1, 16'h0004, 16'h4321);
        chk_buf(4'h2, 16'h4321);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        chk_buf(4'h2, 16'hffff);
        bus(1'b0, 32'h0, 32'h0);
        chk("control after reset", 32'h0, rd);
        complete_run();
    end
endmodule
